// ==== spb_master.sv ====
// expansion bus master: apb registers, location store and sequencer
//
// Function
// - past channel eight, step to the next module address and continue
// - sixteen switch module addresses, chained modules counted upward
// - state option stores 1 for high input, 0 for low
// - duty option stores percentage of interval the input was high
// - counts option stores number of rising transitions
// - signature: positive good, zero program fault, negative data fault
// - one option per run, from start channel 1..8, one channel per rep
// - results go to consecutive locations from start, one per rep
// - reading times multiplier plus offset; no multiplier stores zero
// - silent switch module gets the error value stored instead
// - analog: four mV values per module, next address every four reps
// - analog and control addresses are two base-four digits, 00..33
// - control module: send address, then all sixteen port states
// - sixteen consecutive locations per rep, next rep next module
// - non-zero location sends active port, zero sends inactive
// - up to sixteen control modules, reps equal modules addressed
`timescale 1ns/1ns
module spb_master #(
    parameter int NLOC = 64
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic bus_data_line_i,
    output logic bus_data_line_o,
    output logic bus_data_line_oe_o,
    output logic bus_clock_handshake_line_o,
    output logic bus_module_enable_line_o
);
    localparam int LOC_W = $clog2(NLOC);

    typedef enum logic [2:0] {
        ST_IDLE, ST_GATHER, ST_XFER, ST_WAIT, ST_STORE, ST_NEXT
    } spb_st_t;

    logic [31:0] mem [NLOC];

    spb_st_t st_r, st_nxt;
    spb_pkg::spb_op_t op_r, op_nxt;
    logic [1:0] func_r, func_nxt;
    spb_pkg::spb_cfg_t cfg_r, cfg_nxt;
    logic [31:0] mult_r, mult_nxt;
    logic [31:0] offs_r, offs_nxt;
    logic done_r, done_nxt;
    logic noresp_r, noresp_nxt;
    logic [7:0] reps_r, reps_nxt;
    logic [3:0] addr_r, addr_nxt;
    logic [2:0] chan_r, chan_nxt;
    logic [7:0] loc_r, loc_nxt;
    logic [1:0] sub_r, sub_nxt;
    logic [3:0] gcnt_r, gcnt_nxt;
    logic [15:0] ports_r, ports_nxt;
    logic start_r, start_nxt;
    logic [4:0] txl_r, txl_nxt;
    logic [4:0] rxl_r, rxl_nxt;
    logic [spb_pkg::TX_W-1:0] txd_r, txd_nxt;
    logic [31:0] rdata_nxt;
    logic pready_nxt, pslverr_nxt;

    logic acc, wr, is_mem, mapped, go, finish;
    logic [LOC_W-1:0] pidx, ridx;
    logic [31:0] rword;
    logic mwe;
    logic [LOC_W-1:0] mwa;
    logic [31:0] mwd;
    logic signed [31:0] reading;
    logic signed [63:0] prod;
    logic [31:0] scaled;
    logic [2:0] opc;
    logic [2:0] sub3;
    logic [3:0] chan_cfg;
    spb_pkg::spb_line_t line;
    logic [spb_pkg::RX_W-1:0] rx;
    logic xdone;

    spb_shift u_shift (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .start_i(start_r),
        .tx_len_i(txl_r),
        .tx_data_i(txd_r),
        .rx_len_i(rxl_r),
        .data_i(bus_data_line_i),
        .line_o(line),
        .rx_o(rx),
        .done_o(xdone)
    );

    assign bus_data_line_o = line.data;
    assign bus_data_line_oe_o = line.data_oe;
    assign bus_clock_handshake_line_o = line.clk;
    assign bus_module_enable_line_o = line.en;

    // zero wait states: setup cycle arms pready for the access cycle
    assign acc = psel_i & penable_i & pready_o;
    assign wr = acc & pwrite_i;
    assign is_mem = (paddr_i >= spb_pkg::OFF_MEM) &&
        (paddr_i < 12'(spb_pkg::OFF_MEM + 12'(NLOC * 4)));
    assign pidx = LOC_W'((paddr_i - spb_pkg::OFF_MEM) >> 2);
    assign go = wr && (paddr_i == spb_pkg::OFF_CTRL) &&
        pwdata_i[spb_pkg::CTRL_START] && (st_r == ST_IDLE);
    assign finish = (st_r == ST_NEXT) && (reps_r == 8'h01);

    // location read port for the sequencer
    assign ridx = LOC_W'(loc_r + 8'(gcnt_r));
    assign rword = mem[ridx];

    assign reading = 32'(signed'(rx[spb_pkg::DAT_W-1:0]));
    assign prod = reading * signed'(mult_r);
    assign scaled = (mult_r == 32'h0) ? 32'h0 : 32'(prod[31:0] + offs_r);

    assign opc = (op_r == spb_pkg::SPB_OP_AO) ? spb_pkg::OPC_AO :
        (op_r == spb_pkg::SPB_OP_CD) ? spb_pkg::OPC_CD : {1'b0, func_r};
    assign sub3 = (op_r == spb_pkg::SPB_OP_SW) ? chan_r :
        (op_r == spb_pkg::SPB_OP_AO) ? {1'b0, sub_r} : 3'h0;
    assign chan_cfg = 4'(cfg_r.chan - 4'h1);

    always_comb begin
        mapped = is_mem;
        rdata_nxt = 32'h0;
        unique case (paddr_i)
            spb_pkg::OFF_CTRL: begin
                mapped = 1'b1;
                rdata_nxt[spb_pkg::CTRL_OP_LSB +: 2] = op_r;
                rdata_nxt[spb_pkg::CTRL_FUNC_LSB +: 2] = func_r;
            end
            spb_pkg::OFF_CFG: begin
                mapped = 1'b1;
                rdata_nxt[23:0] = cfg_r;
            end
            spb_pkg::OFF_MULT: begin
                mapped = 1'b1;
                rdata_nxt = mult_r;
            end
            spb_pkg::OFF_OFFS: begin
                mapped = 1'b1;
                rdata_nxt = offs_r;
            end
            spb_pkg::OFF_STAT: begin
                mapped = 1'b1;
                rdata_nxt[spb_pkg::STAT_BUSY] = (st_r != ST_IDLE);
                rdata_nxt[spb_pkg::STAT_DONE] = done_r;
                rdata_nxt[spb_pkg::STAT_NORESP] = noresp_r;
                rdata_nxt[spb_pkg::STAT_ADDR_LSB +: 4] = addr_r;
            end
            default: begin
                if (is_mem) begin
                    rdata_nxt = mem[pidx];
                end
            end
        endcase
        pready_nxt = psel_i & ~penable_i;
        pslverr_nxt = psel_i & ~penable_i & ~mapped;
    end

    // software registers; settings are frozen while a run is active
    always_comb begin
        op_nxt = op_r;
        func_nxt = func_r;
        cfg_nxt = cfg_r;
        mult_nxt = mult_r;
        offs_nxt = offs_r;
        done_nxt = done_r;
        noresp_nxt = noresp_r;
        if (wr && st_r == ST_IDLE) begin
            unique case (paddr_i)
                spb_pkg::OFF_CTRL: begin
                    op_nxt = spb_pkg::spb_op_t'(
                        pwdata_i[spb_pkg::CTRL_OP_LSB +: 2]);
                    func_nxt = pwdata_i[spb_pkg::CTRL_FUNC_LSB +: 2];
                end
                spb_pkg::OFF_CFG: cfg_nxt = pwdata_i[23:0];
                spb_pkg::OFF_MULT: mult_nxt = pwdata_i;
                spb_pkg::OFF_OFFS: offs_nxt = pwdata_i;
                default: ;
            endcase
        end
        // write one to clear; a set in the same cycle wins
        if (wr && paddr_i == spb_pkg::OFF_STAT) begin
            if (pwdata_i[spb_pkg::STAT_DONE]) begin
                done_nxt = 1'b0;
            end
            if (pwdata_i[spb_pkg::STAT_NORESP]) begin
                noresp_nxt = 1'b0;
            end
        end
        if (finish || (go && cfg_r.reps == 8'h00)) begin
            done_nxt = 1'b1;
        end
        if (st_r == ST_STORE && op_r == spb_pkg::SPB_OP_SW && rx[16]) begin
            noresp_nxt = 1'b1;
        end
    end

    // sequencer
    always_comb begin
        st_nxt = st_r;
        reps_nxt = reps_r;
        addr_nxt = addr_r;
        chan_nxt = chan_r;
        loc_nxt = loc_r;
        sub_nxt = sub_r;
        gcnt_nxt = gcnt_r;
        ports_nxt = ports_r;
        start_nxt = 1'b0;
        txl_nxt = txl_r;
        rxl_nxt = rxl_r;
        txd_nxt = txd_r;
        mwe = 1'b0;
        mwa = ridx;
        mwd = scaled;
        unique case (st_r)
            ST_IDLE: begin
                gcnt_nxt = 4'h0;
                if (go && cfg_r.reps != 8'h00) begin
                    reps_nxt = cfg_r.reps;
                    // two base-four digits in one nibble
                    addr_nxt = cfg_r.addr;
                    // start channel 1..8, other values read as 1
                    chan_nxt = (cfg_r.chan == 4'h0 || cfg_r.chan > 4'h8) ?
                        3'h0 : chan_cfg[2:0];
                    loc_nxt = cfg_r.loc;
                    sub_nxt = 2'h0;
                    st_nxt = ST_GATHER;
                end
            end
            ST_GATHER: begin
                if (op_r == spb_pkg::SPB_OP_CD) begin
                    // any non-zero word means port active
                    ports_nxt = {ports_r[14:0], |rword};
                    gcnt_nxt = 4'(gcnt_r + 4'h1);
                    if (gcnt_r == spb_pkg::CD_LAST) begin
                        st_nxt = ST_XFER;
                    end
                end else begin
                    ports_nxt = rword[15:0];
                    st_nxt = ST_XFER;
                end
            end
            ST_XFER: begin
                start_nxt = 1'b1;
                txd_nxt = {addr_r, opc, sub3, ports_r};
                if (op_r == spb_pkg::SPB_OP_SW) begin
                    txl_nxt = spb_pkg::LEN_HDR;
                    rxl_nxt = spb_pkg::LEN_RX;
                end else begin
                    txl_nxt = spb_pkg::LEN_TX;
                    rxl_nxt = spb_pkg::LEN_NONE;
                end
                st_nxt = ST_WAIT;
            end
            ST_WAIT: begin
                if (xdone) begin
                    st_nxt = (op_r == spb_pkg::SPB_OP_SW) ? ST_STORE : ST_NEXT;
                end
            end
            ST_STORE: begin
                mwe = 1'b1;
                // high ack bit means nobody answered
                mwd = rx[16] ? spb_pkg::ERR_VAL : scaled;
                st_nxt = ST_NEXT;
            end
            ST_NEXT: begin
                reps_nxt = 8'(reps_r - 8'h01);
                gcnt_nxt = 4'h0;
                unique case (op_r)
                    spb_pkg::SPB_OP_CD: begin
                        loc_nxt = 8'(loc_r + spb_pkg::CD_PORTS);
                        addr_nxt = 4'(addr_r + 4'h1);
                    end
                    spb_pkg::SPB_OP_AO: begin
                        loc_nxt = 8'(loc_r + 8'h01);
                        sub_nxt = 2'(sub_r + 2'h1);
                        // every four reps the next address
                        if (sub_r == spb_pkg::AO_LAST) begin
                            addr_nxt = 4'(addr_r + 4'h1);
                        end
                    end
                    default: begin
                        loc_nxt = 8'(loc_r + 8'h01);
                        chan_nxt = 3'(chan_r + 3'h1);
                        if (chan_r == spb_pkg::CH_LAST) begin
                            addr_nxt = 4'(addr_r + 4'h1);
                        end
                    end
                endcase
                st_nxt = finish ? ST_IDLE : ST_GATHER;
            end
            default: st_nxt = ST_IDLE;
        endcase
        if (!mwe && wr && is_mem) begin
            mwe = 1'b1;
            mwa = pidx;
            mwd = pwdata_i;
        end
    end

    // locations: sequencer store has priority over a bus write
    always_ff @(posedge clk_sys_i) begin
        if (mwe) begin
            mem[mwa] <= mwd;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st_r <= ST_IDLE;
            op_r <= spb_pkg::SPB_OP_SW;
            func_r <= 2'h0;
            cfg_r <= '0;
            mult_r <= 32'h0;
            offs_r <= 32'h0;
            done_r <= 1'b0;
            noresp_r <= 1'b0;
            reps_r <= 8'h00;
            addr_r <= 4'h0;
            chan_r <= 3'h0;
            loc_r <= 8'h00;
            sub_r <= 2'h0;
            gcnt_r <= 4'h0;
            ports_r <= 16'h0000;
            start_r <= 1'b0;
            txl_r <= 5'h00;
            rxl_r <= 5'h00;
            txd_r <= '0;
            prdata_o <= 32'h0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            func_r <= func_nxt;
            cfg_r <= cfg_nxt;
            mult_r <= mult_nxt;
            offs_r <= offs_nxt;
            done_r <= done_nxt;
            noresp_r <= noresp_nxt;
            reps_r <= reps_nxt;
            addr_r <= addr_nxt;
            chan_r <= chan_nxt;
            loc_r <= loc_nxt;
            sub_r <= sub_nxt;
            gcnt_r <= gcnt_nxt;
            ports_r <= ports_nxt;
            start_r <= start_nxt;
            txl_r <= txl_nxt;
            rxl_r <= rxl_nxt;
            txd_r <= txd_nxt;
            prdata_o <= rdata_nxt;
            pready_o <= pready_nxt;
            pslverr_o <= pslverr_nxt;
        end
    end
endmodule : spb_master

// ==== spb_pkg.sv ====
// constants, types and register map of the expansion bus master
package spb_pkg;
    localparam int CLK_NS = 20;
    localparam int HALF_NS = 80;
    // least time, rounded up to whole cycles
    localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;

    localparam int HDR_W = 10;
    localparam int DAT_W = 16;
    localparam int TX_W = HDR_W + DAT_W;
    localparam int RX_W = DAT_W + 1;
    localparam logic [4:0] LEN_HDR = 5'h0a;
    localparam logic [4:0] LEN_TX = 5'h1a;
    localparam logic [4:0] LEN_RX = 5'h11;
    localparam logic [4:0] LEN_NONE = 5'h00;

    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_CFG = 12'h004;
    localparam logic [11:0] OFF_MULT = 12'h008;
    localparam logic [11:0] OFF_OFFS = 12'h00c;
    localparam logic [11:0] OFF_STAT = 12'h010;
    localparam logic [11:0] OFF_MEM = 12'h100;

    localparam int CTRL_START = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_FUNC_LSB = 4;
    localparam int CFG_REPS_LSB = 0;
    localparam int CFG_ADDR_LSB = 8;
    localparam int CFG_CHAN_LSB = 12;
    localparam int CFG_LOC_LSB = 16;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_NORESP = 2;
    localparam int STAT_ADDR_LSB = 8;

    localparam logic [2:0] OPC_AO = 3'h4;
    localparam logic [2:0] OPC_CD = 3'h5;
    localparam logic [2:0] CH_LAST = 3'h7;
    localparam logic [1:0] AO_LAST = 2'h3;
    localparam logic [3:0] CD_LAST = 4'hf;
    localparam logic [7:0] CD_PORTS = 8'h10;
    localparam logic [31:0] ERR_VAL = 32'hfffe7961;

    typedef enum logic [1:0] {
        SPB_OP_SW,
        SPB_OP_AO,
        SPB_OP_CD,
        SPB_OP_RSV
    } spb_op_t;

    typedef struct packed {
        logic data;
        logic data_oe;
        logic clk;
        logic en;
    } spb_line_t;

    typedef struct packed {
        logic [7:0] loc;
        logic [3:0] chan;
        logic [3:0] addr;
        logic [7:0] reps;
    } spb_cfg_t;
endpackage : spb_pkg

// ==== spb_shift.sv ====
// serial engine: frames one module transaction on the three bus lines
`timescale 1ns/1ns
module spb_shift (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic start_i,
    input wire logic [4:0] tx_len_i,
    input wire logic [spb_pkg::TX_W-1:0] tx_data_i,
    input wire logic [4:0] rx_len_i,
    input wire logic data_i,
    output spb_pkg::spb_line_t line_o,
    output logic [spb_pkg::RX_W-1:0] rx_o,
    output logic done_o
);
    typedef enum logic [1:0] {SH_IDLE, SH_TX, SH_RX} spb_sh_t;

    spb_sh_t st_r, st_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [4:0] n_r, n_nxt;
    logic [4:0] rxl_r, rxl_nxt;
    logic [spb_pkg::TX_W-1:0] sh_r, sh_nxt;
    logic [spb_pkg::RX_W-1:0] rx_nxt;
    spb_pkg::spb_line_t line_nxt;
    logic done_nxt;
    logic din_m_r, din_s_r;
    logic half_end;

    assign half_end = (cnt_r == 8'(spb_pkg::HALF_CYC - 1));

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = half_end ? 8'h00 : 8'(cnt_r + 8'h01);
        n_nxt = n_r;
        rxl_nxt = rxl_r;
        sh_nxt = sh_r;
        rx_nxt = rx_o;
        line_nxt = line_o;
        done_nxt = 1'b0;
        unique case (st_r)
            SH_IDLE: begin
                cnt_nxt = 8'h00;
                if (start_i) begin
                    line_nxt.en = 1'b1;
                    line_nxt.data_oe = 1'b1;
                    line_nxt.clk = 1'b0;
                    sh_nxt = tx_data_i;
                    line_nxt.data = tx_data_i[spb_pkg::TX_W-1];
                    n_nxt = tx_len_i;
                    rxl_nxt = rx_len_i;
                    rx_nxt = '0;
                    st_nxt = SH_TX;
                end
            end
            SH_TX: begin
                if (half_end) begin
                    line_nxt.clk = ~line_o.clk;
                    if (line_o.clk) begin
                        sh_nxt = {sh_r[spb_pkg::TX_W-2:0], 1'b0};
                        line_nxt.data = sh_r[spb_pkg::TX_W-2];
                        n_nxt = 5'(n_r - 5'h01);
                        if (n_r == 5'h01) begin
                            if (rxl_r == spb_pkg::LEN_NONE) begin
                                line_nxt.en = 1'b0;
                                line_nxt.data_oe = 1'b0;
                                done_nxt = 1'b1;
                                st_nxt = SH_IDLE;
                            end else begin
                                line_nxt.data_oe = 1'b0;
                                n_nxt = rxl_r;
                                st_nxt = SH_RX;
                            end
                        end
                    end
                end
            end
            SH_RX: begin
                if (half_end) begin
                    line_nxt.clk = ~line_o.clk;
                    // sample late in the high half, after the sync delay
                    if (line_o.clk) begin
                        rx_nxt = {rx_o[spb_pkg::RX_W-2:0], din_s_r};
                        n_nxt = 5'(n_r - 5'h01);
                        if (n_r == 5'h01) begin
                            line_nxt.en = 1'b0;
                            done_nxt = 1'b1;
                            st_nxt = SH_IDLE;
                        end
                    end
                end
            end
            default: st_nxt = SH_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        din_m_r <= data_i;
        din_s_r <= din_m_r;
        if (srst_i) begin
            st_r <= SH_IDLE;
            cnt_r <= 8'h00;
            n_r <= 5'h00;
            rxl_r <= 5'h00;
            sh_r <= '0;
            rx_o <= '0;
            line_o <= '0;
            done_o <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            n_r <= n_nxt;
            rxl_r <= rxl_nxt;
            sh_r <= sh_nxt;
            rx_o <= rx_nxt;
            line_o <= line_nxt;
            done_o <= done_nxt;
        end
    end
endmodule : spb_shift

// ==== spb_master_asserts.sv ====
// checker on the expansion bus lines of the bus master
`timescale 1ns/1ns
module spb_chk (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic pslverr_o,
    input wire logic bus_data_line_o,
    input wire logic bus_data_line_oe_o,
    input wire logic bus_clock_handshake_line_o,
    input wire logic bus_module_enable_line_o
);
    logic [4:0] rise_r;
    logic [4:0] rise_nxt;
    logic bclk_r;
    wire logic en = bus_module_enable_line_o;
    wire logic bclk = bus_clock_handshake_line_o;
    always_comb begin
        rise_nxt = en ? rise_r : 5'h00;
        if (bclk && !bclk_r) begin
            rise_nxt = rise_nxt + 5'h01;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        rise_r <= srst_i ? 5'h00 : rise_nxt;
        bclk_r <= srst_i ? 1'b0 : bclk;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    chk_clk_idle: assert property (
        !en |-> !bclk) else $error("bus clock runs outside a frame");
    chk_oe_in_frame: assert property (
        bus_data_line_oe_o |-> en) else $error("data driven without enable");
    chk_high_half: assert property (
        $rose(bclk) |-> bclk [*4] ##1 !bclk) else $error("high half not 4");
    chk_low_half: assert property (
        $fell(bclk) |-> !bclk [*4]) else $error("low half too short");
    chk_en_lead: assert property (
        $rose(en) |-> !bclk [*4] ##1 bclk) else $error("enable not first");
    chk_data_hold: assert property (
        bus_data_line_oe_o && bclk |-> $stable(bus_data_line_o))
        else $error("data moved while clock high");
    chk_en_tail: assert property (
        $fell(en) |-> $past(bclk) || $past(bclk, 2) || $past(bclk, 3))
        else $error("enable dropped late");
    chk_frame_bits: assert property (
        $fell(en) |-> rise_r == 5'h1a || rise_r == 5'h1b)
        else $error("frame bit count wrong");
    cover property ($fell(en) && rise_r == 5'h1b);
    cover property ($fell(en) && rise_r == 5'h1a);
    cover property (pslverr_o);
endmodule : spb_chk
bind spb_master spb_chk chk_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .pslverr_o(pslverr_o), .bus_data_line_o(bus_data_line_o),
    .bus_data_line_oe_o(bus_data_line_oe_o),
    .bus_clock_handshake_line_o(bus_clock_handshake_line_o),
    .bus_module_enable_line_o(bus_module_enable_line_o));

// ==== spb_module_model.sv ====
// behavioural expansion module: logs frames, answers switch reads
`timescale 1ns/1ns
module spb_module_model (
    input wire logic en_i,
    input wire logic bclk_i,
    input wire logic line_i,
    input wire logic mst_oe_i,
    input wire logic present_i,
    output logic data_o,
    output logic oe_o
);
    logic [25:0] sh_r = 26'h0;
    logic [16:0] rsp_r;
    logic [25:0] log_r [0:127];
    int nbit_r = 0, k_r = 0, nlog_r = 0;
    initial data_o = 1'b0;
    initial oe_o = 1'b0;
    // bits taken on rising clock, address first
    always @(posedge bclk_i) begin
        if (en_i && mst_oe_i) begin
            sh_r = {sh_r[24:0], line_i};
            nbit_r++;
        end
    end
    // ack low then reading; silent module never drives
    always @(negedge bclk_i) begin
        if (en_i && nbit_r == 10 && !sh_r[5]) begin
            if (k_r == 0) rsp_r = {1'b0, sh_r[9:0], 6'h15};
            oe_o = present_i;
            data_o = (k_r < 17) ? rsp_r[16 - k_r] : !data_o;
            k_r++;
        end
    end
    always @(negedge en_i) begin
        log_r[nlog_r] = sh_r;
        nlog_r++;
        nbit_r = 0;
        k_r = 0;
        oe_o = 1'b0;
        sh_r = 26'h0;
    end
endmodule : spb_module_model

// ==== spb_master_tb.sv ====
// self-checking testbench of the expansion bus master
`timescale 1ns/1ns
module spb_master_tb;
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, m, o;
    logic [31:0] v [0:39];
    logic pready, pslverr, err, m_do, m_oe, bclk, en, s_do, s_oe;
    logic present = 1'b1;
    logic [3:0] a, ch;
    logic [7:0] reps, loc;
    logic [15:0] e;
    int err_count = 0, tests_run = 0, seed = 32'h76f3, base;
    // pull-up holds the data wire high when nobody drives
    wire logic line = m_oe ? m_do : (s_oe ? s_do : 1'b1);
    initial forever #10 clk = ~clk;
    spb_master #(.NLOC(64)) dut_u (.clk_sys_i(clk), .srst_i(srst),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .bus_data_line_i(line), .bus_data_line_o(m_do),
        .bus_data_line_oe_o(m_oe), .bus_clock_handshake_line_o(bclk),
        .bus_module_enable_line_o(en));
    spb_module_model part_u (.en_i(en), .bclk_i(bclk), .line_i(line),
        .mst_oe_i(m_oe), .present_i(present), .data_o(s_do), .oe_o(s_oe));
    task automatic stop_test();
        if (err_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    task automatic check(string nm, logic [31:0] ex, logic [31:0] sn);
        tests_run++;
        if (sn !== ex) begin
            $display("Error %s expected %h seen %h", nm, ex, sn);
            err_count++;
        end
    endtask : check
    task automatic apb(logic w, logic [11:0] ad, logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // no cycle count assumed: pready ends this wait, or else the watchdog
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    function automatic logic [11:0] mem(int i);
        return spb_pkg::OFF_MEM + 12'(i * 4);
    endfunction : mem
    function automatic logic [31:0] sw_exp(logic [3:0] ad, logic [1:0] f,
        logic [3:0] c, logic [31:0] ml, logic [31:0] of);
        logic signed [31:0] r;
        r = $signed({ad, 1'b0, f, c[2:0] - 3'h1, 6'h15});
        return (ml == 32'h0) ? 32'h0 : r * $signed(ml) + $signed(of);
    endfunction : sw_exp
    task automatic run(logic [1:0] op, logic [1:0] f, logic [7:0] rp,
        logic [3:0] ad, logic [3:0] c, logic [7:0] l);
        int n;
        n = 0;
        apb(1'b1, spb_pkg::OFF_STAT, 32'h6);
        apb(1'b1, spb_pkg::OFF_MULT, m);
        apb(1'b1, spb_pkg::OFF_OFFS, o);
        apb(1'b1, spb_pkg::OFF_CFG, {8'h00, l, c, ad, rp});
        apb(1'b1, spb_pkg::OFF_CTRL, {26'h0, f, 1'b0, op, 1'b1});
        do begin
            apb(1'b0, spb_pkg::OFF_STAT, 32'h0);
            n++;
        end while (rd[1] !== 1'b1 && n < 3000);
        check("done", 32'h1, {31'h0, rd[1]});
    endtask : run
    initial begin
        #2000000;
        err_count++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        for (int f = 0; f < 4; f++) begin
            a = 4'($random(seed));
            ch = (f == 0) ? 4'h8 : 4'(($random(seed) & 7) + 1);
            reps = (f == 3) ? 8'h01 : 8'(($random(seed) & 7) + 3);
            loc = 8'($random(seed) & 31);
            m = (f == 2) ? 32'h0 : 32'($random(seed) % 100);
            o = $random(seed);
            base = part_u.nlog_r;
            run(2'h0, 2'(f), reps, a, ch, loc);
            for (int r = 0; r < reps; r++) begin
                apb(1'b0, mem(loc + r), 32'h0);
                check("sw loc", sw_exp(a, 2'(f), ch, m, o), rd);
                check("sw hdr", {22'h0, a, 1'b0, 2'(f), ch[2:0] - 3'h1},
                    {22'h0, part_u.log_r[base + r][9:0]});
                ch = (ch == 4'h8) ? 4'h1 : ch + 4'h1;
                a = (ch == 4'h1) ? a + 4'h1 : a;
            end
        end
        present <= 1'b0;
        m = 32'h1;
        base = part_u.nlog_r;
        // start channel out of range reads as channel one
        run(2'h0, 2'h0, 8'h03, 4'h5, 4'h9, 8'h32);
        check("noresp", 32'h1, {31'h0, rd[2]});
        for (int r = 0; r < 3; r++) begin
            apb(1'b0, mem(50 + r), 32'h0);
            check("err val", spb_pkg::ERR_VAL, rd);
            check("clamp hdr", {22'h0, 4'h5, 3'h0, 3'(r)},
                {22'h0, part_u.log_r[base + r][9:0]});
        end
        present <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            v[i] = ($random(seed) & 1) ? 32'($random(seed)) : 32'h0;
            apb(1'b1, mem(i), v[i]);
        end
        base = part_u.nlog_r;
        run(2'h1, 2'h0, 8'h08, 4'hf, 4'h1, 8'h00);
        for (int r = 0; r < 8; r++) begin
            check("ao frame", {6'h0, 4'hf + 4'(r / 4), 3'h4, 3'(r % 4),
                v[r][15:0]}, {6'h0, part_u.log_r[base + r]});
        end
        a = 4'($random(seed));
        base = part_u.nlog_r;
        run(2'h2, 2'h0, 8'h02, a, 4'h1, 8'h08);
        for (int r = 0; r < 2; r++) begin
            for (int j = 0; j < 16; j++) e[15 - j] = (v[8 + 16 * r + j] != 0);
            check("cd frame", {6'h0, a + 4'(r), 6'h28, e},
                {6'h0, part_u.log_r[base + r]});
        end
        apb(1'b0, 12'h020, 32'h0);
        check("slverr", 32'h1, {31'h0, err});
        check("unmapped", 32'h0, rd);
        stop_test();
    end
endmodule : spb_master_tb
